// file: fhpc_pkg.sv
// shared constants and carrier types for the flash host port block
package fhpc_pkg;
   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned PAR_MAX_HZ = 116_000_000;
   localparam int unsigned SER_MAX_HZ = 7_250_000;
   localparam int unsigned SLOW_DIV = (CLK_HZ + SER_MAX_HZ - 1) / SER_MAX_HZ;
   localparam int unsigned PAR_DIV = (CLK_HZ + PAR_MAX_HZ - 1) / PAR_MAX_HZ;
   localparam int unsigned SER_BITS = 32;
   localparam int unsigned WR_BC_PAR = 1;
   // ----------------------------------------
   // burst sizing
   // ----------------------------------------
   localparam int unsigned MIN_BURST = 2;
   localparam int unsigned MAX_BURST = 128;
   localparam int unsigned WRAP_SHORT = 2;
   localparam int unsigned WRAP_LONG = 4;
   // ----------------------------------------
   // storage and sector map
   // ----------------------------------------
   localparam int unsigned SECT_WORDS = 16;
   localparam int unsigned NUM_SECT = 4;
   localparam int unsigned MEM_WORDS = SECT_WORDS * NUM_SECT;
   localparam int unsigned IDX_W = 6;
   localparam logic [31:0] ERASED = 32'hffff_ffff;
   localparam logic [31:0] DEF_FILL = 32'h5a5a_0000;
   localparam logic [1:0] AM_RW = 2'h0;
   localparam logic [1:0] AM_RO = 2'h1;
   localparam logic [1:0] AM_HIDDEN = 2'h2;
   localparam int unsigned CM_DUAL = 0;
   localparam int unsigned CM_SINGLE_UNC = 1;
   localparam int unsigned CM_SINGLE_CMP = 2;
   localparam int unsigned VAR_SMALL = 0;
   localparam int unsigned VAR_MID = 1;
   localparam int unsigned VAR_LARGE = 2;
   // ----------------------------------------
   // register indices, byte address is index times four
   // ----------------------------------------
   localparam logic [2:0] REG_STATUS = 3'h0;
   localparam logic [2:0] REG_CONTROL = 3'h1;
   localparam logic [2:0] REG_ADDR = 3'h2;
   localparam logic [2:0] REG_BURST = 3'h3;
   localparam logic [2:0] REG_STREAM = 3'h4;
   localparam logic [2:0] REG_WDATA = 3'h5;
   localparam logic [2:0] REG_INFO = 3'h6;
   localparam logic [3:0] CONTROL_RST = 4'h0;
   localparam logic [1:0] BUSY_IDLE = 2'h0;
   localparam logic [1:0] BUSY_WRITE = 2'h2;
   localparam logic [1:0] BUSY_READ = 2'h3;
   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic wr;
      logic [2:0] idx;
   } fhpc_areq_t;
   typedef struct packed {
      logic empty;
      logic wr_ok;
      logic rd_ok;
      logic [1:0] busy;
   } fhpc_stat_t;
endpackage : fhpc_pkg

// file: fhpc_tick.sv
// enable divider that paces flash word transfers
`timescale 1ns/1ps
module fhpc_tick #(
   parameter int unsigned DIV = 1
) (
   // clock and reset
   input wire logic hclk,
   input wire logic rst_n,
   // control
   input wire logic en,
   output logic tick
);
   logic [3:0] cnt_r;
   localparam logic [3:0] LAST = 4'(DIV - 1);

   always_ff @(posedge hclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 4'h0;
      end else if (!en || cnt_r == LAST) begin
         cnt_r <= 4'h0;
      end else begin
         cnt_r <= cnt_r + 4'h1;
      end
   end

   assign tick = en && cnt_r == LAST;
endmodule : fhpc_tick

// file: fhpc_port.sv
// flash host port: ahb-lite register slave, burst read and word program engine
// Contract
// - data interface chosen at build time, parallel by default
// - incrementing bursts use power-of-two lengths from 2 to 128; parallel port accepts any count from 1 up to the setting
// - wrapping bursts fixed at 2 or 4 words by variant
// - serial interface only does incrementing bursts; master avoids wrapping
// - smallest variant has no wrapping bursts in parallel mode
// - parallel burst count setting is the largest accepted burst, default 2
// - serial burst setting is words streamed per read, 32 bits each
// - single uncompressed image adds config sector two as user space
// - single compressed image adds config sectors two and three
// - each sector has own access mode; hidden only for config sectors
// - reset asserts asynchronously, releases on rising clock edge
// - control/status decoded by one address bit, 32-bit data
// - data address width set by configuration mode alone
// - initial content optional, off by default, user content selectable
// - wait held while programming, and on a stream read until a word is ready; master stalls meanwhile
// - write burst count fixed at 1 parallel, 32 serial
`timescale 1ns/1ps
module fhpc_port #(
   parameter bit PARALLEL = 1'b1,
   parameter bit WRAP = 1'b0,
   parameter int unsigned VARIANT = fhpc_pkg::VAR_LARGE,
   parameter int unsigned READ_BURST = 2,
   parameter int unsigned CONFIG_MODE = fhpc_pkg::CM_SINGLE_UNC,
   parameter logic [7:0] SECT_MODE = 8'h00,
   parameter bit INIT_ON = 1'b0,
   parameter bit INIT_USER = 1'b0,
   parameter logic [31:0] USER_FILL = 32'h0000_0000
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp
);
   // ----------------------------------------
   // build-time derivations
   // ----------------------------------------
   function automatic int unsigned legal_rb(input int unsigned v);
      legal_rb = (v >= fhpc_pkg::MIN_BURST && v <= fhpc_pkg::MAX_BURST
                  && (v & (v - 1)) == 0) ? v : fhpc_pkg::MIN_BURST;
   endfunction : legal_rb

   function automatic int unsigned map_words(input int unsigned m);
      map_words = (m == fhpc_pkg::CM_SINGLE_CMP) ? fhpc_pkg::MEM_WORDS :
                  (m == fhpc_pkg::CM_SINGLE_UNC) ? 3 * fhpc_pkg::SECT_WORDS :
                  2 * fhpc_pkg::SECT_WORDS;
   endfunction : map_words

   function automatic logic [31:0] init_word(input int unsigned i);
      init_word = !INIT_ON ? fhpc_pkg::ERASED :
                  INIT_USER ? USER_FILL : fhpc_pkg::DEF_FILL | 32'(i);
   endfunction : init_word

   localparam int unsigned RB = legal_rb(READ_BURST);
   localparam bit WRAP_EN = WRAP && PARALLEL && VARIANT != fhpc_pkg::VAR_SMALL;
   localparam int unsigned WRAP_LEN = (VARIANT == fhpc_pkg::VAR_LARGE) ?
                                      fhpc_pkg::WRAP_LONG : fhpc_pkg::WRAP_SHORT;
   localparam int unsigned MAP_W = map_words(CONFIG_MODE);
   localparam int unsigned ADDR_W = $clog2(MAP_W);
   localparam bit SLOW = !PARALLEL || VARIANT == fhpc_pkg::VAR_SMALL;
   localparam int unsigned DIV_EFF = SLOW ? fhpc_pkg::SLOW_DIV : fhpc_pkg::PAR_DIV;
   localparam int unsigned WORD_BITS = PARALLEL ? fhpc_pkg::WR_BC_PAR : fhpc_pkg::SER_BITS;
   localparam int unsigned IDXW = fhpc_pkg::IDX_W;
   localparam logic [IDXW-1:0] WMASK = IDXW'(WRAP_LEN - 1);
   localparam logic [4:0] BIT_LAST = 5'(WORD_BITS - 1);
   localparam logic [7:0] RB8 = 8'(RB);
   localparam logic [7:0] WRAP8 = 8'(WRAP_LEN);
   localparam logic [IDXW:0] MAP_LIM = (IDXW + 1)'(MAP_W);

   // access mode of a sector, hidden refused on user sectors
   function automatic logic [1:0] smode(input logic [IDXW-1:0] a);
      logic [1:0] s;
      logic [1:0] m;
      s = a[IDXW-1:IDXW-2];
      m = SECT_MODE[{s, 1'b0} +: 2];
      smode = (s < 2'h2 && m == fhpc_pkg::AM_HIDDEN) ? fhpc_pkg::AM_RW : m;
   endfunction : smode

   // ----------------------------------------
   // reset synchroniser
   // ----------------------------------------
   logic rst_meta_r;
   logic rst_n;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   // ----------------------------------------
   // state and storage
   // ----------------------------------------
   typedef enum logic [1:0] {PH_IDLE, PH_DATA, PH_STREAM, PH_PROG} fhpc_ph_t;
   typedef enum logic [1:0] {EN_IDLE, EN_FETCH, EN_HOLD, EN_PROG} fhpc_en_t;
   fhpc_ph_t ph_r;
   fhpc_en_t eng_r;
   fhpc_pkg::fhpc_areq_t acc_r;
   fhpc_pkg::fhpc_stat_t stat;
   logic [31:0] mem_r [fhpc_pkg::MEM_WORDS];
   logic [31:0] hrdata_r, word_r, wdata_r;
   logic hreadyout_r, hresp_r, hold_v_r, err_r, rd_ok_r, wr_ok_r, empty_r;
   logic [3:0] ctrl_r;
   logic [IDXW-1:0] addr_r, cur_r;
   logic [7:0] left_r;
   logic [4:0] bit_r;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire take = hsel && htrans[1] && hready;
   wire in_data = ph_r == PH_DATA;
   wire rd_busy = eng_r == EN_FETCH || eng_r == EN_HOLD;
   wire csr_sel = acc_r.idx[2:1] == 2'h0;
   wire eng_idle = eng_r == EN_IDLE;
   wire tick;
   wire word_done = tick && bit_r == BIT_LAST;
   wire cur_mapped = {1'b0, cur_r} < MAP_LIM;
   wire addr_mapped = {1'b0, addr_r} < MAP_LIM;
   wire cur_legal = cur_mapped && smode(cur_r) != fhpc_pkg::AM_HIDDEN;
   wire writable = addr_mapped && smode(addr_r) == fhpc_pkg::AM_RW
                   && !ctrl_r[addr_r[IDXW-1:IDXW-2]];
   wire [IDXW-1:0] lin = cur_r + IDXW'(1);
   wire [IDXW-1:0] nxt = WRAP_EN ? ((cur_r & ~WMASK) | (lin & WMASK)) : lin;
   wire [7:0] bc_req = hwdata[7:0];
   wire bc_ok = !PARALLEL || WRAP_EN || (bc_req != 8'h0 && bc_req <= RB8);
   wire [7:0] bc_eff = !PARALLEL ? RB8 : WRAP_EN ? WRAP8 : bc_req;
   wire wr_now = in_data && acc_r.wr;
   wire start_rd = wr_now && acc_r.idx == fhpc_pkg::REG_BURST && eng_idle;
   wire prog_req = wr_now && acc_r.idx == fhpc_pkg::REG_WDATA && eng_idle;
   wire start_pg = prog_req && writable;
   wire strm_rd = in_data && !acc_r.wr && acc_r.idx == fhpc_pkg::REG_STREAM;
   wire pop = (strm_rd || ph_r == PH_STREAM) && hold_v_r;
   wire to_wait = strm_rd && !hold_v_r && rd_busy;
   wire [1:0] busy = eng_r == EN_PROG ? fhpc_pkg::BUSY_WRITE :
                     rd_busy ? fhpc_pkg::BUSY_READ : fhpc_pkg::BUSY_IDLE;
   assign stat = '{empty: empty_r, wr_ok: wr_ok_r, rd_ok: rd_ok_r, busy: busy};
   wire [31:0] csr_val = acc_r.idx[0] ? {28'h0, ctrl_r} : {27'h0, stat};
   wire [31:0] info = {16'h0, RB8, 1'b0, 1'(PARALLEL), 1'(WRAP_EN),
                       2'(CONFIG_MODE), 3'(VARIANT)};
   wire [31:0] rd_mux = csr_sel ? csr_val :
      acc_r.idx == fhpc_pkg::REG_ADDR ? 32'(addr_r) :
      acc_r.idx == fhpc_pkg::REG_BURST ? {24'h0, left_r} :
      acc_r.idx == fhpc_pkg::REG_STREAM ? (hold_v_r ? word_r : fhpc_pkg::ERASED) :
      acc_r.idx == fhpc_pkg::REG_INFO ? info : 32'h0;

   fhpc_tick #(
      .DIV(DIV_EFF)
   ) u_tick (
      .hclk(hclk),
      .rst_n(rst_n),
      .en(eng_r == EN_FETCH || eng_r == EN_PROG),
      .tick(tick)
   );

   // ----------------------------------------
   // bus phase
   // ----------------------------------------
   always_ff @(posedge hclk or negedge rst_n) begin
      if (!rst_n) begin
         ph_r <= PH_IDLE;
         acc_r <= '0;
         hreadyout_r <= 1'b1;
         hrdata_r <= 32'h0;
         hresp_r <= 1'b0;
      end else begin
         case (ph_r)
            PH_IDLE: begin
               if (take) begin
                  acc_r <= '{wr: hwrite, idx: haddr[4:2]};
                  hreadyout_r <= 1'b0;
                  ph_r <= PH_DATA;
               end
            end
            PH_DATA: begin
               if (to_wait) begin
                  ph_r <= PH_STREAM;
               end else if (start_pg) begin
                  ph_r <= PH_PROG;
               end else begin
                  hrdata_r <= acc_r.wr ? 32'h0 : rd_mux;
                  hreadyout_r <= 1'b1;
                  ph_r <= PH_IDLE;
               end
            end
            PH_STREAM: begin
               if (hold_v_r || !rd_busy) begin
                  hrdata_r <= hold_v_r ? word_r : fhpc_pkg::ERASED;
                  hreadyout_r <= 1'b1;
                  ph_r <= PH_IDLE;
               end
            end
            PH_PROG: begin
               if (eng_idle) begin
                  hrdata_r <= 32'h0;
                  hreadyout_r <= 1'b1;
                  ph_r <= PH_IDLE;
               end
            end
            default: ph_r <= PH_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   always_ff @(posedge hclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= fhpc_pkg::CONTROL_RST;
         addr_r <= '0;
         wdata_r <= fhpc_pkg::ERASED;
      end else if (wr_now) begin
         if (acc_r.idx == fhpc_pkg::REG_CONTROL) ctrl_r <= hwdata[3:0];
         if (acc_r.idx == fhpc_pkg::REG_ADDR && eng_idle) addr_r <= hwdata[ADDR_W-1:0];
         if (prog_req) wdata_r <= hwdata;
      end
   end

   // ----------------------------------------
   // read and program engine
   // ----------------------------------------
   always_ff @(posedge hclk or negedge rst_n) begin
      if (!rst_n) begin
         eng_r <= EN_IDLE;
         cur_r <= '0;
         left_r <= 8'h0;
         word_r <= fhpc_pkg::ERASED;
         hold_v_r <= 1'b0;
         bit_r <= 5'h0;
         err_r <= 1'b0;
         rd_ok_r <= 1'b0;
         wr_ok_r <= 1'b0;
         empty_r <= 1'b0;
      end else begin
         if (tick) bit_r <= word_done ? 5'h0 : bit_r + 5'h1;
         case (eng_r)
            EN_IDLE: begin
               if (start_rd && bc_ok) begin
                  cur_r <= addr_r;
                  left_r <= bc_eff;
                  err_r <= 1'b0;
                  empty_r <= 1'b0;
                  eng_r <= EN_FETCH;
               end else if (start_rd) begin
                  rd_ok_r <= 1'b0;
                  empty_r <= 1'b1;
               end else if (start_pg) begin
                  cur_r <= addr_r;
                  eng_r <= EN_PROG;
               end else if (prog_req) begin
                  wr_ok_r <= 1'b0;
               end
            end
            EN_FETCH: begin
               if (word_done) begin
                  word_r <= cur_legal ? mem_r[cur_r] : fhpc_pkg::ERASED;
                  err_r <= err_r || !cur_legal;
                  empty_r <= empty_r || !cur_legal;
                  hold_v_r <= 1'b1;
                  eng_r <= EN_HOLD;
               end
            end
            EN_HOLD: begin
               if (pop) begin
                  hold_v_r <= 1'b0;
                  if (left_r == 8'h1) begin
                     rd_ok_r <= !err_r;
                     left_r <= 8'h0;
                     eng_r <= EN_IDLE;
                  end else begin
                     left_r <= left_r - 8'h1;
                     cur_r <= nxt;
                     eng_r <= EN_FETCH;
                  end
               end
            end
            EN_PROG: begin
               if (word_done) begin
                  wr_ok_r <= 1'b1;
                  eng_r <= EN_IDLE;
               end
            end
            default: eng_r <= EN_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // flash array, programming only clears bits
   // ----------------------------------------
   for (genvar i = 0; i < fhpc_pkg::MEM_WORDS; i++) begin : g_mem
      always_ff @(posedge hclk or negedge rst_n) begin
         if (!rst_n) begin
            mem_r[i] <= init_word(i);
         end else if (eng_r == EN_PROG && word_done && cur_r == IDXW'(i)) begin
            mem_r[i] <= mem_r[i] & wdata_r;
         end
      end
   end

   assign hrdata = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp = hresp_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   localparam int unsigned WORD_CYC = WORD_BITS * DIV_EFF;
   logic [15:0] stay_r;
   always_ff @(posedge hclk or negedge rst_n) begin
      if (!rst_n) stay_r <= 16'h0;
      else if (eng_r == EN_FETCH || eng_r == EN_PROG) stay_r <= stay_r + 16'h1;
      else stay_r <= 16'h0;
   end

   sequence s_status_rd;
      take && !hwrite && haddr[4:2] == fhpc_pkg::REG_STATUS;
   endsequence
   sequence s_answer;
      ##2 hreadyout_r;
   endsequence

   a_wait_prog: assert property (@(posedge hclk) disable iff (!rst_n)
      ph_r == PH_PROG |-> !hreadyout_r) else $error("ready during program");
   a_wait_stream: assert property (@(posedge hclk) disable iff (!rst_n)
      to_wait |=> ph_r == PH_STREAM && !hreadyout_r) else $error("stream wait lost");
   a_word_time: assert property (@(posedge hclk) disable iff (!rst_n)
      (eng_r == EN_FETCH || eng_r == EN_PROG) && word_done
      |-> stay_r == 16'(WORD_CYC - 1)) else $error("word time wrong");
   a_wrap_block: assert property (@(posedge hclk) disable iff (!rst_n)
      eng_r == EN_HOLD && pop && left_r != 8'h1 && WRAP_EN
      |=> (cur_r & ~WMASK) == ($past(cur_r) & ~WMASK)) else $error("wrap left block");
   a_incr_step: assert property (@(posedge hclk) disable iff (!rst_n)
      eng_r == EN_HOLD && pop && left_r != 8'h1 && !WRAP_EN
      |=> cur_r == $past(cur_r) + IDXW'(1)) else $error("increment wrong");
   a_burst_limit: assert property (@(posedge hclk) disable iff (!rst_n)
      rd_busy |-> left_r != 8'h0 && left_r <= (WRAP_EN ? WRAP8 : RB8))
      else $error("burst too long");
   a_hidden_read: assert property (@(posedge hclk) disable iff (!rst_n)
      eng_r == EN_FETCH && word_done && !cur_legal
      |=> word_r == fhpc_pkg::ERASED && empty_r) else $error("hidden data seen");
   a_status_read: assert property (@(posedge hclk) disable iff (!rst_n)
      s_status_rd |-> s_answer ##0 hrdata_r[1:0] == $past(busy))
      else $error("status read wrong");
   a_prog_busy: assert property (@(posedge hclk) disable iff (!rst_n)
      start_pg |=> busy == fhpc_pkg::BUSY_WRITE [*1] ##1 !hreadyout_r)
      else $error("program not busy");
endmodule : fhpc_port

// file: fhpc_master.sv
// ahb-lite master model that stands on the far side of the flash host port
`timescale 1ns/1ps
module fhpc_master (
   // clock
   input wire logic hclk,
   // request
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   // answer
   input wire logic [31:0] hrdata,
   input wire logic hreadyout
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
   end
   // ----------------------------------------
   // single word transfer, incrementing only
   // ----------------------------------------
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      haddr <= ~a;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
      hwdata <= ~wd;
   endtask : xfer
endmodule : fhpc_master

// file: tb.sv
// self-checking bench for the flash host port
`timescale 1ns/1ps
module tb;
   logic hclk;
   logic hresetn;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic s_hsel, s_hwrite, s_hreadyout, s_hresp;
   logic [1:0] s_htrans;
   logic [2:0] s_hsize;
   logic [31:0] s_haddr, s_hwdata, s_hrdata;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;
   logic [31:0] mem [64];
   logic [31:0] v;
   logic [31:0] w;
   logic [3:0] prot;
   int a;
   int n;

   fhpc_port #(.READ_BURST(4), .SECT_MODE(8'h04)) fhpc_port_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
   fhpc_master m_i (
      .hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout));
   // serial instance, wrapping requested but refused
   fhpc_port #(.PARALLEL(1'b0), .WRAP(1'b1), .READ_BURST(2),
      .SECT_MODE(8'h20)) fhpc_port_s_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(s_hsel), .haddr(s_haddr), .htrans(s_htrans),
      .hwrite(s_hwrite), .hsize(s_hsize), .hwdata(s_hwdata), .hready(s_hreadyout),
      .hrdata(s_hrdata), .hreadyout(s_hreadyout), .hresp(s_hresp));
   fhpc_master ms_i (
      .hclk(hclk), .hsel(s_hsel), .haddr(s_haddr), .htrans(s_htrans), .hwrite(s_hwrite),
      .hsize(s_hsize), .hwdata(s_hwdata), .hrdata(s_hrdata), .hreadyout(s_hreadyout));

   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         close_out();
      end
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic close_out;
      if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic wr(input logic [2:0] idx, input logic [31:0] d);
      logic [31:0] r;
      m_i.xfer(1'b1, {27'h0, idx, 2'h0}, d, r);
   endtask : wr
   task automatic rd(input logic [2:0] idx, output logic [31:0] r);
      m_i.xfer(1'b0, {27'h0, idx, 2'h0}, 32'h0, r);
   endtask : rd
   task automatic xs(input logic wn, input logic [2:0] idx, input logic [31:0] d,
                     output logic [31:0] r);
      ms_i.xfer(wn, {27'h0, idx, 2'h0}, d, r);
   endtask : xs
   function automatic bit okw(input int x);
      return x < 48 && (x < 16 || x > 31) && !prot[(x >> 4) & 3];
   endfunction : okw
   task automatic prog(input int x, input logic [31:0] d);
      wr(fhpc_pkg::REG_ADDR, 32'(x));
      wr(fhpc_pkg::REG_WDATA, d);
      if (okw(x)) mem[x] &= d;
      rd(fhpc_pkg::REG_STATUS, v);
      chk("write ok", {31'h0, okw(x)}, {31'h0, v[3]});
   endtask : prog
   task automatic burst(input int x, input int c);
      bit ok;
      bit inmap;
      ok = c >= 1 && c <= 4;
      inmap = x + c <= 48;
      wr(fhpc_pkg::REG_ADDR, 32'(x));
      wr(fhpc_pkg::REG_BURST, 32'(c));
      for (int i = 0; i < (ok ? c : 1); i++) begin
         rd(fhpc_pkg::REG_STREAM, v);
         chk("stream", ok && x + i < 48 ? mem[x + i] : 32'hffff_ffff, v);
      end
      rd(fhpc_pkg::REG_STATUS, v);
      chk("read status", ok && inmap ? 32'h4 : 32'h8, {28'h0, v[4], v[2], v[1:0]});
   endtask : burst
   task automatic do_reset;
      hresetn <= 1'b0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
      foreach (mem[i]) mem[i] = 32'hffff_ffff;
      prot = 4'h0;
   endtask : do_reset
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      hresetn = 1'b0;
      void'($urandom(26789));
      do_reset();
      rd(fhpc_pkg::REG_STATUS, v);
      chk("busy", 32'h0, {30'h0, v[1:0]});
      rd(fhpc_pkg::REG_INFO, v);
      chk("info", 32'h044a, v & 32'hff7f);
      rd(3'h7, v);
      chk("unmapped", 32'h0, v);
      chk("hresp", 32'h0, {31'h0, hresp});
      w = $urandom;
      xs(1'b0, fhpc_pkg::REG_INFO, 32'h0, v);
      chk("serial info", 32'h020a, v);
      xs(1'b1, fhpc_pkg::REG_ADDR, 32'h4, v);
      xs(1'b1, fhpc_pkg::REG_WDATA, w, v);
      for (int k = 0; k < 2; k++) begin
         xs(1'b1, fhpc_pkg::REG_ADDR, k ? 32'h20 : 32'h3, v);
         xs(1'b1, fhpc_pkg::REG_BURST, 32'h7, v);
         xs(1'b0, fhpc_pkg::REG_STREAM, 32'h0, v);
         chk("serial first", 32'hffff_ffff, v);
         xs(1'b0, fhpc_pkg::REG_STREAM, 32'h0, v);
         chk("serial second", k ? 32'hffff_ffff : w, v);
         xs(1'b0, fhpc_pkg::REG_STATUS, 32'h0, v);
         chk("serial status", k ? 32'h18 : 32'hc, v & 32'h1f);
      end
      chk("serial hresp", 32'h0, {31'h0, s_hresp});
      prog(48, 32'h0);
      burst(50, 2);
      burst(0, 5);
      burst(0, 0);
      prog(44, $urandom);
      burst(44, 4);
      prog(20, 32'h0);
      for (int k = 0; k < 12; k++) begin
         w = $urandom;
         wr(fhpc_pkg::REG_CONTROL, w);
         rd(fhpc_pkg::REG_CONTROL, v);
         chk("control", {28'h0, w[3:0]}, {28'h0, v[3:0]});
         prot = w[3:0];
         a = $urandom_range(0, 46);
         prog(a, $urandom);
         prog(a + 1, $urandom);
         n = $urandom_range(1, 4);
         if (a + n > 48) n = 48 - a;
         burst(a, n);
      end
      wr(fhpc_pkg::REG_CONTROL, 32'h0);
      prot = 4'h0;
      prog(2, 32'h0);
      do_reset();
      rd(fhpc_pkg::REG_CONTROL, v);
      chk("control", 32'h0, {28'h0, v[3:0]});
      burst(2, 1);
      close_out();
   end
endmodule : tb
